// ---- src/bmsp_port.sv ----
// Serial command/response frame port of a stackable cell monitor.
// Assumes the link pins arrive asynchronous to ref_clk, which runs
// well above the serial clock so every edge is seen after sync.
`timescale 1ns/1ps
`include "bmsp_cfg.svh"

// Functional notes
// - Link runs mode 1: clock idles low, data captured on trailing edge.
// - Inbound data bits are sampled on the serial clock falling edge.
// - Outbound data bits are launched on the serial clock rising edge.
// - Only 32-bit frames; bit counter cleared on every select rising edge. Counter stops at 32, so longer frames act on their first 32 bits.
// - Valid write to control upper byte starts conversion at select rise.
// - Write frame: dev 31..27, reg 26..21, data 20..13, all, 0, CRC, trailer.
// - Device holds a 5-bit stack address, zero after power-up.
// - Device address travels LSB first; other fields MSB first.
// - Bit 12 set makes every device apply the write, address zero.
// - CRC over bits 31..11 checked; mismatch means no write.
// - Trailer bits 2..0 must equal 010 or the write is dropped.
// - Write data is one 8-bit value.
// - Conversion response: dev, channel, 12-bit result, ack, CRC, zeros.
// - Register response: dev, reg, data, zeros, ack, CRC, zeros.
// - Response CRC over bits 31..10 placed in bits 9..2.
// - Next response ack shows whether the last write aimed at this device executed.
// - Conversion field holds a 12-bit cell, auxiliary or self-test result.
// - Register response data is contents of the previously selected register.
// - One 32-bit write updates any register of any stacked device.
// - Nonzero read select gives register responses; zero gives conversions.
// - Ack passes down the chain with both zero and nonzero read select.
module bmsp_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link pins
  input wire logic selN,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  // Conversion data source
  input wire logic [3:0] convChannel,
  input wire logic [11:0] convResult,
  output logic convNext,
  // Register file access
  output logic wrStrobe,
  output logic [5:0] wrAddr,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData,
  output logic [5:0] rdSel,
  // Device identity and events
  input wire logic [4:0] devAddrIn,
  input wire logic devAddrLoad,
  output logic [4:0] devAddr,
  output logic convStart,
  output logic writeAck
);
  typedef struct packed {
    logic [2:0] selSync;
    logic [2:0] sclkSync;
    logic [1:0] sdiSync;
    bmsp_pkg::bmsp_state_t state;
    logic [5:0] bitCnt;
    logic [31:0] rxShift;
    logic [31:0] txShift;
    logic [7:0] txCrc;
    logic txCrcIns;
    logic sdo;
    logic sdoOe;
    logic convNext;
    logic wrStrobe;
    logic [5:0] wrAddr;
    logic [7:0] wrData;
    logic [5:0] rdSel;
    logic [4:0] devAddr;
    logic convStart;
    logic ack;
    logic pendStart;
  } bmsp_port_state_t;

  bmsp_port_state_t st_reg;
  bmsp_port_state_t st_next;

  logic selLow;
  logic selFall;
  logic selRise;
  logic sclkRise;
  logic sclkFall;
  logic rxBit;
  logic [7:0] rxCrc;
  logic [7:0] txCrcCalc;
  logic txCrcBit;
  logic [31:0] respFrame;

  // ---------------------------------------------------------------
  // Pin edge detection on the second and third sync stages
  // ---------------------------------------------------------------
  // Stage 0 feeds stage 1 only; edges compare stages 1 and 2
  assign selLow = !st_reg.selSync[1];
  assign selFall = st_reg.selSync[2] && !st_reg.selSync[1];
  assign selRise = !st_reg.selSync[2] && st_reg.selSync[1];
  assign sclkRise = !st_reg.sclkSync[2] && st_reg.sclkSync[1];
  assign sclkFall = st_reg.sclkSync[2] && !st_reg.sclkSync[1];
  assign rxBit = st_reg.sdiSync[1];

  // Bit-reverse helper for the LSB-first device address
  function automatic logic [4:0] bmsp_rev5(input logic [4:0] v);
    bmsp_rev5 = {v[0], v[1], v[2], v[3], v[4]};
  endfunction : bmsp_rev5

  // ---------------------------------------------------------------
  // Response frame build (CRC field filled in while shifting)
  // ---------------------------------------------------------------
  always_comb begin
    respFrame = '0;
    respFrame[`BMSP_DEV_HI:`BMSP_DEV_LO] = bmsp_rev5(st_reg.devAddr);
    respFrame[`BMSP_ACK_BIT] = st_reg.ack;
    if (st_reg.rdSel != 6'h00) begin
      respFrame[`BMSP_REG_HI:`BMSP_REG_LO] = st_reg.rdSel;
      respFrame[`BMSP_DAT_HI:`BMSP_DAT_LO] = rdData;
    end else begin
      respFrame[`BMSP_CH_HI:`BMSP_CH_LO] = convChannel;
      respFrame[`BMSP_RES_HI:`BMSP_RES_LO] = convResult;
    end
  end

  // Outbound CRC accumulates bits 31..10 as they leave
  bmsp_crc8 txCrcUnit (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(selFall),
    .bitEn(sclkRise && st_reg.bitCnt < `BMSP_TX_CRC_BITS
           && st_reg.state == bmsp_pkg::BMSP_SHIFT),
    .bitIn(st_reg.txShift[31]),
    .crc(txCrcCalc)
  );

  // Inbound CRC accumulates bits 31..11 as they arrive
  bmsp_crc8 rxCrcUnit (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(selFall),
    .bitEn(sclkFall && st_reg.bitCnt < `BMSP_RX_CRC_BITS
           && st_reg.state == bmsp_pkg::BMSP_SHIFT),
    .bitIn(rxBit),
    .crc(rxCrc)
  );

  assign txCrcBit = st_reg.txCrc[7];

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  always_comb begin
    logic frameOk;
    logic addrHit;
    logic [4:0] rxDev;
    frameOk = 1'b0;
    addrHit = 1'b0;
    rxDev = 5'h00;
    st_next = st_reg;
    st_next.selSync = {st_reg.selSync[1:0], selN};
    st_next.sclkSync = {st_reg.sclkSync[1:0], sclk};
    st_next.sdiSync = {st_reg.sdiSync[0], sdi};
    st_next.wrStrobe = 1'b0;
    st_next.convStart = 1'b0;
    st_next.convNext = 1'b0;
    // Strap-style address load from the chain logic after lock
    if (devAddrLoad) begin
      st_next.devAddr = devAddrIn;
    end
    unique case (st_reg.state)
      bmsp_pkg::BMSP_IDLE: begin
        st_next.sdoOe = 1'b0;
        if (selFall) begin
          st_next.state = bmsp_pkg::BMSP_SHIFT;
          st_next.bitCnt = 6'h00;
          st_next.txShift = respFrame;
          st_next.txCrcIns = 1'b0;
          st_next.sdoOe = 1'b1;
          st_next.sdo = 1'b0;
        end
      end
      bmsp_pkg::BMSP_SHIFT: begin
        // Launch on rise; first rise presents bit 31
        if (sclkRise) begin
          if (st_reg.bitCnt == `BMSP_TX_CRC_BITS && !st_reg.txCrcIns) begin
            st_next.txCrc = txCrcCalc;
            st_next.txCrcIns = 1'b1;
          end
          if (st_reg.bitCnt >= `BMSP_TX_CRC_BITS && st_reg.bitCnt < `BMSP_TX_CRC_END) begin
            st_next.sdo = (st_reg.bitCnt == `BMSP_TX_CRC_BITS) ? txCrcCalc[7] : txCrcBit;
            st_next.txCrc = (st_reg.bitCnt == `BMSP_TX_CRC_BITS) ?
                            {txCrcCalc[6:0], 1'b0} : {st_reg.txCrc[6:0], 1'b0};
          end else begin
            st_next.sdo = st_reg.txShift[31];
          end
          st_next.txShift = {st_reg.txShift[30:0], 1'b0};
        end
        // Capture on fall
        if (sclkFall && st_reg.bitCnt < `BMSP_FRAME_BITS) begin
          st_next.rxShift = {st_reg.rxShift[30:0], rxBit};
          st_next.bitCnt = st_reg.bitCnt + 6'h01;
        end
        if (selRise) begin
          st_next.state = bmsp_pkg::BMSP_DONE;
          st_next.sdoOe = 1'b0;
        end
      end
      bmsp_pkg::BMSP_DONE: begin
        st_next.state = bmsp_pkg::BMSP_IDLE;
        st_next.bitCnt = 6'h00;
        if (st_reg.bitCnt == `BMSP_FRAME_BITS) begin
          rxDev = bmsp_rev5(st_reg.rxShift[`BMSP_DEV_HI:`BMSP_DEV_LO]);
          addrHit = st_reg.rxShift[`BMSP_ALL_BIT] || (rxDev == st_reg.devAddr);
          frameOk = (st_reg.rxShift[`BMSP_WCRC_HI:`BMSP_WCRC_LO] == rxCrc)
                 && (st_reg.rxShift[`BMSP_TRL_HI:`BMSP_TRL_LO] == `BMSP_TRAILER);
          // Ack reflects the last write aimed at this device
          if (addrHit) begin
            st_next.ack = frameOk;
          end
          if (frameOk && addrHit) begin
            st_next.wrStrobe = 1'b1;
            st_next.wrAddr = st_reg.rxShift[`BMSP_REG_HI:`BMSP_REG_LO];
            st_next.wrData = st_reg.rxShift[`BMSP_DAT_HI:`BMSP_DAT_LO];
            if (st_reg.rxShift[`BMSP_REG_HI:`BMSP_REG_LO] == `BMSP_RDSEL_ADDR) begin
              st_next.rdSel = st_reg.rxShift[`BMSP_DAT_HI:`BMSP_DAT_LO + 2];
            end
            if (st_reg.rxShift[`BMSP_REG_HI:`BMSP_REG_LO] == `BMSP_CTRL_HI_ADDR) begin
              st_next.convStart = 1'b1;
            end
          end
          // Advance conversion stream after a full conversion frame
          st_next.convNext = (st_reg.rdSel == 6'h00);
        end
      end
      default: begin
        st_next.state = bmsp_pkg::BMSP_IDLE;
      end
    endcase
    // Select high always ends a frame, even from idle glitches
    if (!selLow && st_reg.state == bmsp_pkg::BMSP_IDLE) begin
      st_next.sdoOe = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.selSync <= 3'h7;
      st_reg.devAddr <= `BMSP_DEV_RST;
      st_reg.rdSel <= `BMSP_RDSEL_RST;
      st_reg.state <= bmsp_pkg::BMSP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign sdo = st_reg.sdo;
  assign sdoOe = st_reg.sdoOe;
  assign convNext = st_reg.convNext;
  assign wrStrobe = st_reg.wrStrobe;
  assign wrAddr = st_reg.wrAddr;
  assign wrData = st_reg.wrData;
  assign rdSel = st_reg.rdSel;
  assign devAddr = st_reg.devAddr;
  assign convStart = st_reg.convStart;
  assign writeAck = st_reg.ack;
endmodule : bmsp_port

// ---- src/bmsp_cfg.svh ----
// Constants of the battery monitor serial frame port.
// Assumes inclusion by bare name from design files under src/.
`ifndef BMSP_CFG_SVH
`define BMSP_CFG_SVH

// ---------------------------------------------------------------
// Frame geometry
// ---------------------------------------------------------------
`define BMSP_FRAME_BITS 6'h20
// Bit counts at which the outbound and inbound CRC spans end
`define BMSP_TX_CRC_BITS 6'h16
`define BMSP_RX_CRC_BITS 6'h15
`define BMSP_TX_CRC_END 6'h1e
`define BMSP_DEV_HI 31
`define BMSP_DEV_LO 27
`define BMSP_REG_HI 26
`define BMSP_REG_LO 21
`define BMSP_DAT_HI 20
`define BMSP_DAT_LO 13
`define BMSP_ALL_BIT 12
`define BMSP_ZERO_BIT 11
`define BMSP_WCRC_HI 10
`define BMSP_WCRC_LO 3
`define BMSP_TRL_HI 2
`define BMSP_TRL_LO 0
`define BMSP_TRAILER 3'h2
`define BMSP_CH_HI 26
`define BMSP_CH_LO 23
`define BMSP_RES_HI 22
`define BMSP_RES_LO 11
`define BMSP_ACK_BIT 10
`define BMSP_RCRC_HI 9
`define BMSP_RCRC_LO 2

// ---------------------------------------------------------------
// Reset values, register addresses and CRC
// ---------------------------------------------------------------
`define BMSP_DEV_RST 5'h00
`define BMSP_RDSEL_RST 6'h00
`define BMSP_CTRL_HI_ADDR 6'h0d
`define BMSP_RDSEL_ADDR 6'h0e
`define BMSP_CRC_POLY 8'h2f
`define BMSP_CRC_INIT 8'h00

`endif

// ---- src/bmsp_pkg.sv ----
// Types of the battery monitor serial frame port.
// Assumes the constants header is compiled alongside.
package bmsp_pkg;
  // Frame engine state
  typedef enum logic [1:0] {
    BMSP_IDLE = 2'b00,
    BMSP_SHIFT = 2'b01,
    BMSP_DONE = 2'b10
  } bmsp_state_t;
endpackage : bmsp_pkg

// ---- src/bmsp_crc8.sv ----
// Bitwise CRC-8 step over a serial stream, MSB first.
// Assumes the caller clears it at frame start and gates it per bit.
`timescale 1ns/1ps
`include "bmsp_cfg.svh"

module bmsp_crc8 (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Stream
  input wire logic clear,
  input wire logic bitEn,
  input wire logic bitIn,
  // Result
  output logic [7:0] crc
);
  typedef struct packed {
    logic [7:0] crc;
  } bmsp_crc_state_t;

  bmsp_crc_state_t st_reg;
  bmsp_crc_state_t st_next;

  // ---------------------------------------------------------------
  // Linear feedback step
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.crc = `BMSP_CRC_INIT;
    end else if (bitEn) begin
      st_next.crc = {st_reg.crc[6:0], 1'b0} ^
                    ((st_reg.crc[7] ^ bitIn) ? `BMSP_CRC_POLY : 8'h00);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign crc = st_reg.crc;
endmodule : bmsp_crc8

// ---- verification/bmsp_port_assertions.sv ----
// Concurrent checks on the ports of the serial frame port.
// Assumes it is bound to bmsp_port and sees only its ports.
`timescale 1ns/1ps
module bmsp_port_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link pins
  input wire logic selN,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdoOe,
  // Events and state
  input wire logic wrStrobe,
  input wire logic convStart,
  input wire logic convNext,
  input wire logic [5:0] wrAddr,
  input wire logic [5:0] rdSel,
  input wire logic devAddrLoad,
  input wire logic [4:0] devAddr
);
  // -----
  // Properties
  // -----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Released line once the deselect has crossed the synchroniser
  AST_OE_IDLE: assert property (selN [*6] |-> !sdoOe)
    else $error("sdo driven while deselected");
  // A write only lands after select has been high for a while
  AST_STB_LATE: assert property (wrStrobe |-> selN && $past(selN, 3))
    else $error("write before frame end");
  AST_STB_ONE: assert property (wrStrobe |=> !wrStrobe)
    else $error("write strobe too long");
  AST_CONV_WR: assert property (convStart |-> wrStrobe)
    else $error("start without write");
  AST_DEV_HOLD: assert property ($changed(devAddr) |-> $past(devAddrLoad))
    else $error("device address moved");
  AST_RDSEL: assert property ($changed(rdSel) |-> wrStrobe || $past(wrStrobe))
    else $error("read select moved");
  AST_WRADDR: assert property ($changed(wrAddr) |-> wrStrobe || $past(wrStrobe))
    else $error("write address moved");
  // Mid-frame data may only move shortly after a clock rise
  AST_SDO: assert property (sdoOe && $past(sdoOe, 4) && $changed(sdo)
    |-> $past(sclk) || $past(sclk, 2) || $past(sclk, 3))
    else $error("sdo moved off a rise");
  AST_CNXT: assert property (convNext |-> $past(rdSel, 3) == 6'h00 ##1 !convNext)
    else $error("conversion step out of mode");
  COV_WR: cover property (wrStrobe);
  COV_START: cover property (convStart);
  COV_NEXT: cover property (convNext);
endmodule : bmsp_port_assertions

bind bmsp_port bmsp_port_assertions chk (.ref_clk(ref_clk), .nrst(nrst), .selN(selN),
  .sclk(sclk), .sdo(sdo), .sdoOe(sdoOe), .wrStrobe(wrStrobe), .convStart(convStart),
  .convNext(convNext), .wrAddr(wrAddr), .rdSel(rdSel), .devAddrLoad(devAddrLoad),
  .devAddr(devAddr));

// ---- verification/bmsp_host_model.sv ----
// Host model: mode 1 serial master with a 320 ns link clock.
// Assumes the bench calls xfer from one process, one frame at a time.
`timescale 1ns/1ps
module bmsp_host_model (
  // Link pins
  output logic selN,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  // Idle: clock parked low, data not left at the last bit
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  // One frame of n bits, bit 31 first; reply taken at each fall
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h00000000;
    #17 selN = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      #160 sclk = 1'b1;
      sdi = tx[i];
      #160 sclk = 1'b0;
      rx[i] = sdo;
    end
    #160 selN = 1'b1;
    sdi = ~sdi;
    #400;
  endtask : xfer
endmodule : bmsp_host_model

// ---- verification/testbench.sv ----
// Self-checking bench of the serial frame port.
// Assumes the design, host model and checker are compiled before it.
`timescale 1ns/1ps
`include "bmsp_cfg.svh"
module testbench;
  // -----
  // Signals and models
  // -----
  typedef struct packed {logic [31:0] f; logic s; logic c; logic a;} bmsp_row_t;
  localparam logic [4:0] MY = 5'h03;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic devAddrLoad = 1'b0;
  logic ack = 1'b0;
  logic selN, sclk, sdi, uSdo, sdoOe, convNext, wrStrobe, convStart, writeAck;
  logic [5:0] wrAddr, rdSel;
  logic [7:0] wrData;
  logic [4:0] devAddr;
  logic [15:0] conv = 16'h93c5; // Conversion source stand-in: channel and result
  logic [31:0] rx;
  bmsp_row_t rows [7];
  int num_errors = 0;
  int checks_done = 0;
  int nStb = 0;
  int nCnv = 0;
  int nNxt = 0;
  wire logic sdoPin = sdoOe ? uSdo : ~uSdo; // Released line never shows a stale bit
  wire logic [7:0] rdData = {rdSel, 2'b01}; // Register file stand-in
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  bmsp_host_model host (.selN(selN), .sclk(sclk), .sdi(sdi), .sdo(sdoPin));
  bmsp_port uut (.ref_clk(ref_clk), .nrst(nrst), .selN(selN), .sclk(sclk), .sdi(sdi),
    .sdo(uSdo), .sdoOe(sdoOe), .convChannel(conv[15:12]), .convResult(conv[11:0]),
    .convNext(convNext), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
    .rdData(rdData), .rdSel(rdSel), .devAddrIn(MY), .devAddrLoad(devAddrLoad),
    .devAddr(devAddr), .convStart(convStart), .writeAck(writeAck));
  // Pulse counters, so a double or missing strobe shows up
  always @(posedge ref_clk) begin
    nStb <= nStb + int'(wrStrobe === 1'b1);
    nCnv <= nCnv + int'(convStart === 1'b1);
    nNxt <= nNxt + int'(convNext === 1'b1);
  end
  // -----
  // Helpers
  // -----
  function automatic logic [7:0] crc8(input logic [31:0] v, input int n);
    logic [7:0] c;
    c = `BMSP_CRC_INIT;
    for (int i = 31; i > 31 - n; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `BMSP_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8
  function automatic logic [31:0] wr(input logic [4:0] d, input logic [5:0] r,
      input logic [7:0] v, input logic all);
    logic [31:0] f;
    f = {d[0], d[1], d[2], d[3], d[4], r, v, all, 1'b0, 8'h00, 3'b010};
    f[10:3] = crc8(f, 21);
    return f;
  endfunction : wr
  function automatic logic [31:0] rsp(input logic [15:0] m, input logic a);
    logic [31:0] f;
    f = {MY[0], MY[1], MY[2], MY[3], MY[4], m, a, 10'h000};
    f[9:2] = crc8(f, 22);
    return f;
  endfunction : rsp
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic frame(input logic [31:0] f, input int n, input logic s, input logic c);
    int s0, c0;
    s0 = nStb;
    c0 = nCnv;
    host.xfer(f, n, rx);
    check("strobes", nStb - s0, s);
    check("starts", nCnv - c0, c);
  endtask : frame
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end
  // -----
  // Sequence
  // -----
  initial begin
    rows[0] = {wr(MY, 6'h05, 8'ha5, 1'b0), 3'b101};
    rows[1] = {wr(5'h04, 6'h06, 8'h22, 1'b0), 3'b001};
    rows[2] = {wr(MY, 6'h05, 8'h5a, 1'b0) ^ 32'h00000008, 3'b000};
    rows[3] = {wr(MY, 6'h06, 8'h11, 1'b0) ^ 32'h00000007, 3'b000};
    rows[4] = {wr(5'h00, 6'h07, 8'h33, 1'b1), 3'b101};
    rows[5] = {wr(MY, 6'h0d, 8'hc0, 1'b0), 3'b111};
    rows[6] = {wr(MY, 6'h0e, 8'h38, 1'b0), 3'b101};
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("devAddr", devAddr, 5'h00);
    devAddrLoad <= 1'b1;
    @(posedge ref_clk) devAddrLoad <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      frame(rows[i].f, 32, rows[i].s, rows[i].c);
      check("conv reply", rx, rsp({4'h9, 12'h3c5}, ack));
      check("ack", writeAck, rows[i].a);
      if (rows[i].s) check("write", {wrAddr, wrData}, rows[i].f[26:13]);
      ack = rows[i].a;
    end
    check("rdSel", rdSel, 6'h0e);
    frame(32'hf800030a, 32, 1'b0, 1'b0);
    check("reg reply", rx, rsp({6'h0e, 6'h0e, 2'b01, 2'b00}, 1'b1));
    frame(wr(MY, 6'h05, 8'h77, 1'b0), 16, 1'b0, 1'b0);
    frame(wr(MY, 6'h05, 8'h77, 1'b0), 32, 1'b1, 1'b0);
    check("resync", wrData, 8'h77);
    // Back to streamed results; the source moves each frame so stale data shows
    frame(wr(MY, 6'h0e, 8'h00, 1'b0), 32, 1'b1, 1'b0);
    check("rdSel clear", rdSel, 6'h00);
    // Six conversions from each of eight parts; rows gave seven steps before
    for (int k = 0; k < 48; k++) begin
      @(posedge ref_clk) conv <= 16'h93c5 + 16'(k);
      frame(32'hf800030a, 32, 1'b0, 1'b0);
      check("chain reply", rx, rsp(16'h93c5 + 16'(k), 1'b1));
    end
    check("conv steps", nNxt, 32'h37);
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("reset", {devAddr, rdSel, sdoOe, writeAck}, 13'h0000);
    close_out();
  end
endmodule : testbench
